// File: hdl/charger_fault_defines.vh
// Register indices, reset values, field positions and bus codes of the fault flag bank.
// Assumes it is included by bare name from the design files of this block.
`ifndef CHARGER_FAULT_DEFINES_VH
`define CHARGER_FAULT_DEFINES_VH

// Register indices; the byte address is four times the index
`define FAULT_A_IDX     8'h26
`define FAULT_B_IDX     8'h27
`define EVT_MASK_IDX    8'h28
`define IRQ_STATUS_IDX  8'h30
`define IRQ_CLEAR_IDX   8'h31
`define IRQ_ENABLE_IDX  8'h32

// Reset values
`define FAULT_A_RESET   8'h00
`define FAULT_B_RESET   8'h00
`define EVT_MASK_RESET  8'h00
`define IRQ_RESET       3'h0

// Bits of the second fault register that hold flags; the rest are reserved
`define FAULT_B_LIVE    8'hf4

// Interrupt status layout
`define IRQ_W           3
`define IRQ_FAULT_A     0
`define IRQ_FAULT_B     1
`define IRQ_CHG_EVT     2

// Positions of fault inputs in the synchronised vector
`define FLT_N           13
`define FLT_BATT_REG    12
`define FLT_A_TOP       11
`define FLT_A_BOT       5
`define FLT_B_TOP       4
`define FLT_B_BOT       1
`define FLT_TSHUT       0

// AXI4-Lite response codes
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// File: hdl/charger_fault_flag_bank.v
// Fault flag bank of a charger: sticky protection flags, event mask and interrupt logic.
// Assumes asynchronous protection comparator levels and an AXI4-Lite master on aclk.
`timescale 1ns/100ps
`default_nettype none
`include "charger_fault_defines.vh"

// Operation
// R1: Bit7 of flags A on regulation entry/exit
// R2: Bit3 of flags A on discharge overcurrent
// R3: Bit2 of flags A on converter overcurrent
// R4: Bit7 of flags B on system short
// R5: Bit6 of flags B on system overvoltage
// R6: Bit5 of flags B on reverse-output overvoltage
// R7: Bit4 of flags B on reverse-output undervoltage
// R8: Bit2 of flags B on thermal shutdown rise
// R9: Flags A at 26h, zero reset, read-only
// R10: Flags B at 27h, reserved bits read zero
// R11: Mask register at 28h, eight read-write bits
// R12: Mask one suppresses event interrupt pulse
// R13: Flags A bits 6,5,4,1,0 on entry
// R14: Flags stay until read; read clears
module charger_fault_flag_bank (
    input  wire        aclk,                      // System clock, 125 MHz
    input  wire        aresetn,                   // Synchronous reset, active low
    // Protection comparator levels, asynchronous
    input  wire        batt_current_reg_evt,      // Battery current regulation active
    input  wire        bus_overvolt_evt,          // Input bus over-voltage
    input  wire        batt_overvolt_evt,         // Battery over-voltage
    input  wire        input_overcurrent_evt,     // Input over-current
    input  wire        discharge_overcurrent_evt, // Battery discharge over-current
    input  wire        converter_overcurrent_evt, // Converter over-current
    input  wire        input_two_overvolt_evt,    // Second input over-voltage
    input  wire        input_one_overvolt_evt,    // First input over-voltage
    input  wire        system_short_evt,          // System rail short
    input  wire        system_overvolt_evt,       // System rail over-voltage
    input  wire        reverse_out_overvolt_evt,  // Reverse output mode bus too high
    input  wire        reverse_out_undervolt_evt, // Reverse output mode bus too low
    input  wire        thermal_shutdown_evt,      // Die thermal shutdown
    input  wire [7:0]  charger_evt,               // Charger events in mask bit order
    output wire        event_pulse,               // One-cycle pulse on unmasked event
    output wire        irq,                       // Level interrupt, active high
    // AXI4-Lite slave
    input  wire [9:0]  s_axi_awaddr,              // Write address
    input  wire        s_axi_awvalid,             // Write address valid
    output wire        s_axi_awready,             // Write address ready
    input  wire [31:0] s_axi_wdata,               // Write data
    input  wire [3:0]  s_axi_wstrb,               // Write byte strobes
    input  wire        s_axi_wvalid,              // Write data valid
    output wire        s_axi_wready,              // Write data ready
    output wire [1:0]  s_axi_bresp,               // Write response
    output wire        s_axi_bvalid,              // Write response valid
    input  wire        s_axi_bready,              // Write response ready
    input  wire [9:0]  s_axi_araddr,              // Read address
    input  wire        s_axi_arvalid,             // Read address valid
    output wire        s_axi_arready,             // Read address ready
    output wire [31:0] s_axi_rdata,               // Read data
    output wire [1:0]  s_axi_rresp,               // Read response
    output wire        s_axi_rvalid,              // Read data valid
    input  wire        s_axi_rready               // Read data ready
);

    // Synchronised edges and per-register set vectors
    wire [`FLT_N-1:0]  flt_rise;
    wire [`FLT_N-1:0]  flt_fall;
    wire [7:0]         chg_rise;
    wire [7:0]         set_a;
    wire [7:0]         set_b;
    wire [`IRQ_W-1:0]  irq_set;
    wire               chg_hit;
    // Bus decode helpers
    wire               rd_take;
    wire               do_write;
    wire [7:0]         rd_idx;
    wire [7:0]         wr_idx;
    wire               wr_lane0;
    wire               clr_a;
    wire               clr_b;

    // Flag, mask and interrupt state
    reg  [7:0]         fault_a_q;
    reg  [7:0]         fault_a_d;
    reg  [7:0]         fault_b_q;
    reg  [7:0]         fault_b_d;
    reg  [7:0]         evt_mask_q;
    reg  [`IRQ_W-1:0]  irq_status_q;
    reg  [`IRQ_W-1:0]  irq_status_d;
    reg  [`IRQ_W-1:0]  irq_enable_q;
    reg  [`IRQ_W-1:0]  irq_clr;
    reg                event_pulse_q;
    reg                irq_q;

    // Bus channel state; each channel holds one beat at most
    reg                aw_held_q;
    reg  [9:0]         awaddr_q;
    reg                w_held_q;
    reg  [31:0]        wdata_q;
    reg  [3:0]         wstrb_q;
    reg                bvalid_q;
    reg  [1:0]         bresp_q;
    reg                rvalid_q;
    reg  [31:0]        rdata_q;
    reg  [1:0]         rresp_q;
    // Decode results, combinational
    reg  [7:0]         rd_val;
    reg                rd_hit;
    reg                wr_hit;

    // Limitation: a level must stand two cycles or more to be seen at all
    // Vector order follows the flag bit order, top bit first
    // Protection levels cross into aclk here
    level_edge_sync #(
        .W (`FLT_N)
    ) u_flt_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .level_in ({batt_current_reg_evt, bus_overvolt_evt, batt_overvolt_evt,
                    input_overcurrent_evt, discharge_overcurrent_evt,
                    converter_overcurrent_evt, input_two_overvolt_evt,
                    input_one_overvolt_evt, system_short_evt, system_overvolt_evt,
                    reverse_out_overvolt_evt, reverse_out_undervolt_evt,
                    thermal_shutdown_evt}),
        .level_q  (),
        .rise     (flt_rise),
        .fall     (flt_fall)
    );

    // Charger event levels; an entry is a rising edge
    level_edge_sync #(
        .W (8)
    ) u_chg_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .level_in (charger_evt),
        .level_q  (),
        .rise     (chg_rise),
        .fall     ()
    );

    // Regulation flag marks both entry and exit
    assign set_a = {flt_rise[`FLT_BATT_REG] | flt_fall[`FLT_BATT_REG], // [R1]
                    flt_rise[`FLT_A_TOP:`FLT_A_BOT]};                   // [R2] [R3] [R13]
    // Stop conditions and thermal rise; reserved positions stay zero
    assign set_b = {flt_rise[`FLT_B_TOP:`FLT_B_BOT], 1'b0,              // [R4] [R5] [R6] [R7]
                    flt_rise[`FLT_TSHUT], 2'b00} & `FAULT_B_LIVE;      // [R8] [R10]

    // Fault flags are never masked; the mask only gates charger events
    // Masked events never reach the pulse or the status bit
    assign chg_hit = |(chg_rise & ~evt_mask_q); // [R12]

    // A read is taken whenever no answer is waiting
    assign rd_take  = s_axi_arvalid && !rvalid_q;
    assign rd_idx   = s_axi_araddr[9:2];
    assign clr_a    = rd_take && (rd_idx == `FAULT_A_IDX);
    assign clr_b    = rd_take && (rd_idx == `FAULT_B_IDX);
    assign irq_set  = {chg_hit, |set_b, |set_a};

    // Clear lands at the edge that captures the read data, so the value
    // returned is the one from before the clear
    // Limitation: no count of events is kept; a flag only says at least one
    // event came since the last read of its register
    // Read clears a flag; a new event in the same cycle wins over the clear
    always @* begin
        fault_a_d = (fault_a_q & ~{8{clr_a}}) | set_a;                  // [R14]
        fault_b_d = ((fault_b_q & ~{8{clr_b}}) | set_b) & `FAULT_B_LIVE; // [R14] [R10]
        irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
    end

    // Interrupt follows the next status so it rises with the status bit;
    // an enable change shows one cycle after its write lands
    // Flag storage and interrupt state
    always @(posedge aclk) begin
        if (!aresetn) begin
            fault_a_q     <= `FAULT_A_RESET; // [R9]
            fault_b_q     <= `FAULT_B_RESET; // [R10]
            irq_status_q  <= `IRQ_RESET;
            event_pulse_q <= 1'b0;
            irq_q         <= 1'b0;
        end else begin
            fault_a_q     <= fault_a_d;
            fault_b_q     <= fault_b_d;
            irq_status_q  <= irq_status_d;
            event_pulse_q <= chg_hit; // [R12]
            irq_q         <= |(irq_status_d & irq_enable_q);
        end
    end

    // Outputs straight from flops
    assign event_pulse = event_pulse_q;
    assign irq         = irq_q;

    // Trade-off: one write in flight keeps the decode small; writes come
    // at most every third cycle, ample for register traffic
    // Write channel: address and data are taken in either order
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign wr_idx        = awaddr_q[9:2];
    assign wr_lane0      = wstrb_q[0];

    // Only byte lane zero carries register bits; other lanes are ignored
    // Write decode; writes to the flag registers are ignored but answered
    always @* begin
        irq_clr = {`IRQ_W{1'b0}};
        case (wr_idx)
            `FAULT_A_IDX:    wr_hit = 1'b1;
            `FAULT_B_IDX:    wr_hit = 1'b1;
            `EVT_MASK_IDX:   wr_hit = 1'b1;
            `IRQ_STATUS_IDX: wr_hit = 1'b1;
            `IRQ_ENABLE_IDX: wr_hit = 1'b1;
            `IRQ_CLEAR_IDX: begin
                wr_hit = 1'b1;
                if (do_write && wr_lane0) begin
                    irq_clr = wdata_q[`IRQ_W-1:0];
                end
            end
            default:         wr_hit = 1'b0;
        endcase
    end

    // Write handshake and register updates
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            awaddr_q     <= 10'h000;
            w_held_q     <= 1'b0;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            bvalid_q     <= 1'b0;
            bresp_q      <= `RESP_OKAY;
            evt_mask_q   <= `EVT_MASK_RESET; // [R11]
            irq_enable_q <= `IRQ_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                if (wr_lane0 && (wr_idx == `EVT_MASK_IDX)) begin
                    evt_mask_q <= wdata_q[7:0]; // [R11]
                end
                if (wr_lane0 && (wr_idx == `IRQ_ENABLE_IDX)) begin
                    irq_enable_q <= wdata_q[`IRQ_W-1:0];
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Write response straight from flops
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Unmapped reads answer an error with zero data rather than aliasing
    // Read decode; the clear register reads as zero
    always @* begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        case (rd_idx)
            `FAULT_A_IDX:    rd_val = fault_a_q;                 // [R9]
            `FAULT_B_IDX:    rd_val = fault_b_q & `FAULT_B_LIVE; // [R10]
            `EVT_MASK_IDX:   rd_val = evt_mask_q;                // [R11]
            `IRQ_STATUS_IDX: rd_val = {5'h00, irq_status_q};
            `IRQ_ENABLE_IDX: rd_val = {5'h00, irq_enable_q};
            `IRQ_CLEAR_IDX:  rd_val = 8'h00;
            default:         rd_hit = 1'b0;
        endcase
    end

    // Answer comes the cycle after the address is taken; arready stays low
    // while it waits, so a second read cannot overtake the first
    // Read channel: one read at a time, data held until taken
    assign s_axi_arready = !rvalid_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else begin
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= {24'h00_0000, rd_val};
                rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Read answer straight from flops
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule // charger_fault_flag_bank

`default_nettype wire

// File: hdl/level_edge_sync.v
// Bank of three-flop synchronisers with edge detection per bit.
// Assumes asynchronous level inputs and one clock with a synchronous low reset.
`timescale 1ns/100ps
`default_nettype none

module level_edge_sync #(
    parameter W = 8
) (
    input  wire         aclk,     // System clock
    input  wire         aresetn,  // Synchronous reset, active low
    input  wire [W-1:0] level_in, // Asynchronous levels
    output wire [W-1:0] level_q,  // Filtered level
    output wire [W-1:0] rise,     // One-cycle pulse on accepted rise
    output wire [W-1:0] fall      // One-cycle pulse on accepted fall
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg lvl_q;
            reg rise_q;
            reg fall_q;
            // First stage feeds only the second; a change counts when stages two and three agree
            always @(posedge aclk) begin
                if (!aresetn) begin
                    s1_q   <= 1'b0;
                    s2_q   <= 1'b0;
                    s3_q   <= 1'b0;
                    lvl_q  <= 1'b0;
                    rise_q <= 1'b0;
                    fall_q <= 1'b0;
                end else begin
                    s1_q   <= level_in[i];
                    s2_q   <= s1_q;
                    s3_q   <= s2_q;
                    rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
                    fall_q <= (s2_q == s3_q) && !s3_q && lvl_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign level_q[i] = lvl_q;
            assign rise[i]    = rise_q;
            assign fall[i]    = fall_q;
        end
    endgenerate

endmodule // level_edge_sync

`default_nettype wire

// File: sim/fault_bank_monitor.sv
// Checker for the fault flag bank: bus handshakes, reserved bits, event pulse quiet.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module fault_bank_monitor (
    input wire logic        aclk,          // Clock
    input wire logic        aresetn,       // Reset, active low
    input wire logic [7:0]  charger_evt,   // Charger events
    input wire logic        event_pulse,   // Event pulse
    input wire logic        irq,           // Interrupt
    input wire logic        s_axi_awvalid, // AW valid
    input wire logic        s_axi_awready, // AW ready
    input wire logic        s_axi_wvalid,  // W valid
    input wire logic        s_axi_wready,  // W ready
    input wire logic [1:0]  s_axi_bresp,   // B resp
    input wire logic        s_axi_bvalid,  // B valid
    input wire logic        s_axi_bready,  // B ready
    input wire logic [9:0]  s_axi_araddr,  // AR address
    input wire logic        s_axi_arvalid, // AR valid
    input wire logic        s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata,   // R data
    input wire logic [1:0]  s_axi_rresp,   // R resp
    input wire logic        s_axi_rvalid,  // R valid
    input wire logic        s_axi_rready   // R ready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire ar_go = s_axi_arvalid && s_axi_arready;

    // Answers must hold until the master takes them
    AST_BVALID_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_RVALID_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_READ_ANSWER:
    assert property (ar_go |=> s_axi_rvalid) else $error("read not answered");
    AST_WRITE_ANSWER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    // Flag registers are eight bits; reserved flag bits never show
    AST_A_WIDTH:
    assert property (ar_go && s_axi_araddr == 10'h098 |=> s_axi_rdata[31:8] == 24'h0)
        else $error("flags a upper bits set");
    AST_B_RESERVED:
    assert property (ar_go && s_axi_araddr == 10'h09c |=> (s_axi_rdata & 32'hffffff0b) == 0)
        else $error("flags b reserved bit set");
    AST_MASK_OKAY:
    assert property (ar_go && s_axi_araddr == 10'h0a0 |=> s_axi_rresp == 2'b00)
        else $error("mask read refused");
    // No event edge, no pulse; the window covers the synchroniser delay
    AST_EVT_QUIET:
    assert property ($stable(charger_evt) [*8] |-> !event_pulse)
        else $error("pulse without event");
    // Outputs are quiet one cycle into reset
    AST_RESET_QUIET:
    assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs active in reset");
    cover property (irq);
    cover property (event_pulse);
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // fault_bank_monitor

`default_nettype wire

// File: sim/tb.sv
// Self-checking bench of the fault flag bank, driven over AXI4-Lite.
// Assumes the defines header on the include path and the monitor compiled before.
`timescale 1ns/100ps
`default_nettype none
`include "charger_fault_defines.vh"

module tb;
    localparam logic [9:0] FA = {`FAULT_A_IDX, 2'b00};
    localparam logic [9:0] FB = {`FAULT_B_IDX, 2'b00};
    localparam logic [9:0] MK = {`EVT_MASK_IDX, 2'b00};
    localparam logic [9:0] ST = {`IRQ_STATUS_IDX, 2'b00};
    localparam logic [9:0] CL = {`IRQ_CLEAR_IDX, 2'b00};
    localparam logic [9:0] EN = {`IRQ_ENABLE_IDX, 2'b00};
    localparam logic [1:0] OK = `RESP_OKAY;
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  fa = 0, fb = 0, charger_evt = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_bready = 1, s_axi_rready = 1; // Lowered by a scenario to stall an answer
    logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire         event_pulse, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int          fail_count = 0, compares = 0, pulses = 0;

    charger_fault_flag_bank DUT (.*, .batt_current_reg_evt(fa[7]), .bus_overvolt_evt(fa[6]),
        .batt_overvolt_evt(fa[5]), .input_overcurrent_evt(fa[4]),
        .discharge_overcurrent_evt(fa[3]), .converter_overcurrent_evt(fa[2]),
        .input_two_overvolt_evt(fa[1]), .input_one_overvolt_evt(fa[0]),
        .system_short_evt(fb[7]), .system_overvolt_evt(fb[6]),
        .reverse_out_overvolt_evt(fb[5]), .reverse_out_undervolt_evt(fb[4]),
        .thermal_shutdown_evt(fb[2]));

    always #4 aclk = ~aclk;
    // Count pulses so a missing or doubled one shows
    always @(posedge aclk) if (event_pulse === 1'b1) pulses <= pulses + 1;

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Ready is sampled at the falling edge; it only moves after a rising one
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw, w, b, bv;
        logic [1:0] r;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            bv = s_axi_bvalid;
            b = bv & s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (bv && !b) s_axi_bready <= 1'b1; // Stalled answer taken a cycle late
        end while (!b);
        chk("write resp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar, rv, rs;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            rs = s_axi_rvalid;
            rv = rs & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rs && !rv) s_axi_rready <= 1'b1; // Stalled answer taken a cycle late
        end while (!rv);
        chk("read data", d, e);
        chk("read resp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic t_reset;
        logic [9:0] ad[5] = '{FA, FB, MK, ST, EN};
        for (int i = 0; i < 5; i++) rd(ad[i], 0, OK);
    endtask

    // Each fault sets only its bit; a read returns then clears it
    task automatic t_faults;
        int bl[5] = '{7, 6, 5, 4, 2};
        for (int i = 0; i < 8; i++) begin
            fa[i] <= 1'b1;
            idle(8);
            rd(FA, 32'h1 << i, OK);
            rd(FA, 0, OK);
            fa[i] <= 1'b0;
            idle(8);
            rd(FA, i == 7 ? 32'h80 : 0, OK);
        end
        wr(FA, 8'hff, OK);
        rd(FA, 0, OK);
        for (int j = 0; j < 5; j++) begin
            fb[bl[j]] <= 1'b1;
            idle(8);
            rd(FB, 32'h1 << bl[j], OK);
            rd(FB, 0, OK);
            fb[bl[j]] <= 1'b0;
            idle(8);
        end
        fb <= 8'hff;
        idle(8);
        rd(FB, 32'hf4, OK);
        fb <= 8'h00;
    endtask

    // Every mask bit both ways; a masked edge gives no pulse
    task automatic t_mask;
        logic [7:0] m;
        int p;
        for (int k = 0; k < 2; k++) begin
            m = k ? 8'h5a : 8'ha5;
            wr(MK, m, OK);
            rd(MK, m, OK);
            for (int i = 0; i < 8; i++) begin
                p = pulses;
                charger_evt[i] <= 1'b1;
                idle(8);
                chk("event pulses", 32'(pulses - p), {31'h0, !m[i]});
                charger_evt[i] <= 1'b0;
                idle(8);
            end
        end
    endtask

    // Raise, mask and clear the level interrupt; unmapped place refused
    task automatic t_irq;
        rd(ST, 7, OK);
        s_axi_wstrb <= 4'he;
        wr(MK, 8'hff, OK);
        s_axi_wstrb <= 4'hf;
        rd(MK, 32'h5a, OK);
        wr(CL, 8'h07, OK);
        s_axi_bready <= 1'b0;
        wr(EN, 8'h01, OK);
        s_axi_rready <= 1'b0;
        rd(EN, 1, OK);
        fa[3] <= 1'b1;
        idle(8);
        chk("irq", irq, 1);
        wr(EN, 8'h00, OK);
        idle(2);
        chk("irq", irq, 0);
        wr(EN, 8'h01, OK);
        rd(FA, 32'h08, OK);
        fa[3] <= 1'b0;
        wr(CL, 8'h01, OK);
        idle(2);
        chk("irq", irq, 0);
        rd(ST, 0, OK);
        wr(10'h3fc, 8'h00, `RESP_SLVERR);
        rd(10'h3fc, 0, `RESP_SLVERR);
    endtask

    task automatic end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence after a two-cycle reset
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_faults();
        t_mask();
        t_irq();
        end_sim();
    end

    // Whole run needs well under 3000 cycles
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule // tb

bind charger_fault_flag_bank fault_bank_monitor mon (.*);

`default_nettype wire
